// file: verilog/toc_regs.vh
// Register map, field positions, curve constants and timing for the overcurrent element
`ifndef TOC_REGS_VH
`define TOC_REGS_VH

// Timing
`define TOC_CLK_MHZ 10
`define TOC_SAMPLE_US 1000

// Register byte addresses
`define TOC_ADDR_CTRL 8'h00
`define TOC_ADDR_PICKUP 8'h04
`define TOC_ADDR_MULT 8'h08
`define TOC_ADDR_STATUS 8'h0c
`define TOC_ADDR_MASK 8'h10
`define TOC_ADDR_STATE 8'h14
`define TOC_ADDR_ACCUM 8'h18
`define TOC_ADDR_TABADDR 8'h1c
`define TOC_ADDR_TABDATA 8'h20

// Control fields
`define TOC_CTRL_CURVE_MSB 3
`define TOC_CTRL_LINEAR_BIT 4

// Status and mask bits
`define TOC_EV_TRIP 0
`define TOC_EV_PICKUP 1
`define TOC_EV_DROPOUT 2
`define TOC_EV_BITS 3

// Reset values
`define TOC_PICKUP_RST 16'h0100
`define TOC_MULT_RST 14'h0064
`define TOC_CURVE_RST 4'h0
`define TOC_USER_RST 24'h010000

// Scales and limits
`define TOC_FULL 31'h40000000
`define TOC_ONE_PU 32'h00010000
`define TOC_DT_BASE 24'h00199a
`define TOC_MULT_MAX 14'h2710
`define TOC_DROP_PCT 24'h000062
`define TOC_DROP_DEN 24'h000064
`define TOC_CR_STD 4'h5
`define TOC_CR_IEC 4'h8
`define TOC_USER_POINTS 80
`define TOC_USER_STEP_SHIFT 13
`define TOC_RECIP_NUM 64'h0000000100000000

// Curve codes
`define TOC_CURVE_IEC_FIRST 4'h8
`define TOC_CURVE_DT 4'hc
`define TOC_CURVE_USER_A 4'hd
`define TOC_CURVE_USER_B 4'he

// Coefficients {A,B,C,D,E}, signed Q16 seconds, 24 bits each
`define TOC_COEF_ANSI_EI {24'h000a37, 24'h003aba, 24'h008000, 24'h030268, 24'h00b8e2}
`define TOC_COEF_ANSI_VI {24'h000fbf, 24'h00cc85, 24'h00570a, -24'h0048b4, 24'h040cee}
`define TOC_COEF_ANSI_NI {24'h000704, 24'h0242eb, 24'h004ccd, -24'h04309d, 24'h092090}
`define TOC_COEF_ANSI_MI {24'h002c6b, 24'h00adda, 24'h00cccd, -24'h00147b, 24'h00208a}
`define TOC_COEF_ALT_EI {24'h000106, 24'h00a34d, 24'h009eb8, 24'h01c986, 24'h003f00}
`define TOC_COEF_ALT_VI {24'h00170a, 24'h00cba6, 24'h00199a, -24'h0147cf, 24'h07f567}
`define TOC_COEF_ALT_I {24'h003532, 24'h00dcee, 24'h00cccd, -24'h006b02, 24'h0031d8}
`define TOC_COEF_ALT_SI {24'h000af5, 24'h000f97, 24'h009eb8, -24'h000042, 24'h0005a8}
`define TOC_COEF_IEC_A `TOC_COEF_ANSI_EI
`define TOC_COEF_IEC_B `TOC_COEF_ANSI_VI
`define TOC_COEF_IEC_C `TOC_COEF_ANSI_NI
`define TOC_COEF_IEC_S `TOC_COEF_ANSI_MI

`endif

// file: verilog/toc_divider.v
// Sequential restoring divider, one quotient bit per clock
`default_nettype none

module toc_divider #(
  parameter NW = 64,
  parameter DW = 48
) (
  input wire clk,
  input wire reset,
  input wire start,
  input wire [NW-1:0] num,
  input wire [DW-1:0] den,
  output wire busy,
  output reg done,
  output reg [NW-1:0] quot
);

  reg [DW:0] rem_reg;
  reg [6:0] cnt_reg;
  wire [DW:0] remShift = {rem_reg[DW-1:0], quot[NW-1]};
  wire fits = remShift >= {1'b0, den};

  assign busy = cnt_reg != 7'h00;

  // Zero divisor yields all ones, read as immediate full scale
  always @(posedge clk) begin
    if (reset) begin
      rem_reg <= {(DW+1){1'b0}};
      cnt_reg <= 7'h00;
      done <= 1'b0;
      quot <= {NW{1'b0}};
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_reg <= {(DW+1){1'b0}};
        quot <= num;
        cnt_reg <= NW[6:0];
      end else if (busy) begin
        rem_reg <= fits ? remShift - {1'b0, den} : remShift;
        quot <= {quot[NW-2:0], fits};
        cnt_reg <= cnt_reg - 7'h01;
        done <= cnt_reg == 7'h01;
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/toc_user_table.v
// Two user trip-time tables, 80 points each, flip-flop storage
`default_nettype none
`include "toc_regs.vh"

module toc_user_table #(
  parameter POINTS = `TOC_USER_POINTS,
  parameter TW = 24
) (
  input wire clk,
  input wire reset,
  input wire wrEn,
  input wire wrSel,
  input wire [6:0] wrIdx,
  input wire [TW-1:0] wrData,
  input wire rdSelA,
  input wire [6:0] rdIdxA,
  output wire [TW-1:0] rdDataA,
  input wire rdSelB,
  input wire [6:0] rdIdxB,
  output wire [TW-1:0] rdDataB
);

  reg [TW-1:0] mem [0:2*POINTS-1];
  integer i;

  function [7:0] slot;
    input sel;
    input [6:0] idx;
    begin
      slot = (sel ? POINTS[7:0] : 8'h00) + {1'b0, idx};
    end
  endfunction

  assign rdDataA = (rdIdxA < POINTS) ? mem[slot(rdSelA, rdIdxA)] : {TW{1'b0}};
  assign rdDataB = (rdIdxB < POINTS) ? mem[slot(rdSelB, rdIdxB)] : {TW{1'b0}};

  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 2*POINTS; i = i + 1) begin
        mem[i] <= `TOC_USER_RST;
      end
    end else if (wrEn && wrIdx < POINTS) begin
      mem[slot(wrSel, wrIdx)] <= wrData;
    end
  end

endmodule

`default_nettype wire

// file: verilog/toc_element.v
// Inverse-time overcurrent element with register port and interrupt
`default_nettype none
`include "toc_regs.vh"

// Behaviour
// - Accumulate whenever current exceeds pickup.
// - Dropout below 98 percent of pickup.
// - Pickup equals one per unit, CT multiples.
// - Curve code picks standard, definite, user.
// - User curve: 80 trip-time points.
// - Multiplier 0.00 to 100.00, 0.01 steps.
// - Trip time proportional to multiplier.
// - Zero multiplier trips at once.
// - Trip when accumulator reaches full.
// - Below dropout, reset instantly or linearly.
// - Instant mode clears accumulator to zero.
// - Linear full reset takes M times constant seconds.
// - Reset constant 5, or 8 for IEC.
// - Formulas only for ratio above one.
// - Definite time base delay 0.1 seconds.
// - Definite delay 0.00 to 10.00 seconds.
// - Trip time is M times A-E polynomial.
module toc_element #(
  parameter SAMPLE_US = `TOC_SAMPLE_US,
  parameter SAMPLE_CYCLES = SAMPLE_US * `TOC_CLK_MHZ
) (
  input wire clk,
  input wire reset,
  input wire [15:0] currentIn,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  output reg tripOut,
  output reg pickedUp,
  output wire irq
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RATIO = 3'h1;
  localparam [2:0] S_RECIP = 3'h2;
  localparam [2:0] S_BASE = 3'h3;
  localparam [2:0] S_INC = 3'h4;
  localparam [2:0] S_DEC = 3'h5;

  // Fraction of full scale gained per sample when trip time is 1 Q16 second times 0.01
  localparam [63:0] INC_NUM = ((64'h1 << 46) * SAMPLE_US) / 64'h2710;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function [119:0] curveCoef;
    input [3:0] code;
    begin
      case (code)
        4'h0: curveCoef = `TOC_COEF_ANSI_EI;
        4'h1: curveCoef = `TOC_COEF_ANSI_VI;
        4'h2: curveCoef = `TOC_COEF_ANSI_NI;
        4'h3: curveCoef = `TOC_COEF_ANSI_MI;
        4'h4: curveCoef = `TOC_COEF_ALT_EI;
        4'h5: curveCoef = `TOC_COEF_ALT_VI;
        4'h6: curveCoef = `TOC_COEF_ALT_I;
        4'h7: curveCoef = `TOC_COEF_ALT_SI;
        4'h8: curveCoef = `TOC_COEF_IEC_A;
        4'h9: curveCoef = `TOC_COEF_IEC_B;
        4'ha: curveCoef = `TOC_COEF_IEC_C;
        4'hb: curveCoef = `TOC_COEF_IEC_S;
        default: curveCoef = 120'h0;
      endcase
    end
  endfunction

  function isFormula;
    input [3:0] code;
    begin
      isFormula = code < `TOC_CURVE_DT;
    end
  endfunction

  function [6:0] userIndex;
    input [31:0] ratio;
    reg [31:0] steps;
    begin
      steps = (ratio - `TOC_ONE_PU) >> `TOC_USER_STEP_SHIFT;
      if (steps == 32'h0) begin
        userIndex = 7'h00;
      end else if (steps > `TOC_USER_POINTS) begin
        userIndex = 7'h4f;
      end else begin
        userIndex = steps[6:0] - 7'h01;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [31:0] tickCnt_reg;
  reg [2:0] state_reg;
  reg [3:0] curve_reg;
  reg linear_reg;
  reg [15:0] pickup_reg;
  reg [13:0] mult_reg;
  reg [`TOC_EV_BITS-1:0] status_reg;
  reg [`TOC_EV_BITS-1:0] mask_reg;
  reg tabSel_reg;
  reg [6:0] tabIdx_reg;
  reg [30:0] acc_reg;
  reg [31:0] ratio_reg;
  reg [23:0] y_reg;
  reg divStart_reg;
  reg [63:0] divNum_reg;
  reg [47:0] divDen_reg;

  wire divBusy;
  wire divDone;
  wire [63:0] divQuot;
  wire [23:0] userTime;
  wire [23:0] tabReadback;

  // Sample-rate enable from the single clock
  wire sampleTick = tickCnt_reg == SAMPLE_CYCLES - 1;

  // Hysteresis: above pickup starts timing, below 98 percent drops out
  wire [23:0] curScaled = currentIn * `TOC_DROP_DEN;
  wire [23:0] pickScaled = pickup_reg * `TOC_DROP_PCT;
  wire abovePickup = currentIn > pickup_reg;
  wire belowDropout = curScaled < pickScaled;
  wire pickNext = abovePickup | (pickedUp & ~belowDropout);

  wire accFull = acc_reg == `TOC_FULL;
  wire isIec = curve_reg >= `TOC_CURVE_IEC_FIRST && curve_reg < `TOC_CURVE_DT;
  wire [3:0] resetConst = isIec ? `TOC_CR_IEC : `TOC_CR_STD;
  wire [17:0] multReset = mult_reg * resetConst;

  ////////////////////////////////////////////////////////////////////////////
  // Curve evaluation from the reciprocal y = 1/(r - C)

  wire [119:0] coef = curveCoef(curve_reg);
  wire signed [63:0] cA = {{40{coef[119]}}, coef[119:96]};
  wire signed [63:0] cB = {{40{coef[95]}}, coef[95:72]};
  wire [31:0] cC = {8'h00, coef[71:48]};
  wire signed [63:0] cD = {{40{coef[47]}}, coef[47:24]};
  wire signed [63:0] cE = {{40{coef[23]}}, coef[23:0]};
  wire [47:0] ySq = y_reg * y_reg;
  wire [31:0] y2 = ySq[47:16];
  wire [55:0] yCube = y2 * y_reg;
  wire [39:0] y3 = yCube[55:16];
  wire signed [63:0] yS = {40'h0, y_reg};
  wire signed [63:0] y2S = {32'h0, y2};
  wire signed [63:0] y3S = {24'h0, y3};
  wire signed [63:0] poly = cB * yS + cD * y2S + cE * y3S;
  wire signed [63:0] baseQ = cA + (poly >>> 16);
  wire [23:0] baseFormula = (baseQ < 64'sh1) ? 24'h000001 :
                            (baseQ > 64'sh0000000000ffffff) ? 24'hffffff : baseQ[23:0];
  reg [23:0] baseSel;
  always @* begin
    baseSel = baseFormula;
    if (curve_reg == `TOC_CURVE_DT) begin
      baseSel = `TOC_DT_BASE;
    end else if (curve_reg == `TOC_CURVE_USER_A || curve_reg == `TOC_CURVE_USER_B) begin
      baseSel = userTime;
    end
  end
  // Trip time scales linearly with the multiplier
  wire [37:0] incDen = mult_reg * baseSel;

  wire [31:0] ratioNow = (|divQuot[63:32]) ? 32'hffffffff : divQuot[31:0];
  wire [30:0] stepNow = (divQuot > {33'h0, `TOC_FULL}) ? `TOC_FULL : divQuot[30:0];
  wire [31:0] accSum = {1'b0, acc_reg} + {1'b0, stepNow};

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  toc_divider #(
    .NW(64),
    .DW(48)
  ) uDiv (
    .clk(clk),
    .reset(reset),
    .start(divStart_reg),
    .num(divNum_reg),
    .den(divDen_reg),
    .busy(divBusy),
    .done(divDone),
    .quot(divQuot)
  );

  toc_user_table uTable (
    .clk(clk),
    .reset(reset),
    .wrEn(regWr && regAddr == `TOC_ADDR_TABDATA),
    .wrSel(tabSel_reg),
    .wrIdx(tabIdx_reg),
    .wrData(regWdata[23:0]),
    .rdSelA(curve_reg == `TOC_CURVE_USER_B),
    .rdIdxA(userIndex(ratio_reg)),
    .rdDataA(userTime),
    .rdSelB(tabSel_reg),
    .rdIdxB(tabIdx_reg),
    .rdDataB(tabReadback)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timing engine

  always @(posedge clk) begin
    if (reset) begin
      tickCnt_reg <= 32'h0;
      state_reg <= S_IDLE;
      acc_reg <= 31'h0;
      ratio_reg <= 32'h0;
      y_reg <= 24'h0;
      divStart_reg <= 1'b0;
      divNum_reg <= 64'h0;
      divDen_reg <= 48'h0;
      pickedUp <= 1'b0;
      tripOut <= 1'b0;
    end else begin
      divStart_reg <= 1'b0;
      tripOut <= accFull;
      tickCnt_reg <= sampleTick ? 32'h0 : tickCnt_reg + 32'h1;
      if (sampleTick) begin
        pickedUp <= pickNext;
      end
      case (state_reg)
        S_IDLE: begin
          if (sampleTick && !divBusy) begin
            if (pickNext) begin
              if (mult_reg == 14'h0) begin
                acc_reg <= `TOC_FULL;
              end else begin
                divNum_reg <= {32'h0, currentIn, 16'h0};
                divDen_reg <= {32'h0, pickup_reg};
                divStart_reg <= 1'b1;
                state_reg <= S_RATIO;
              end
            end else if (!linear_reg || mult_reg == 14'h0) begin
              acc_reg <= 31'h0;
            end else if (acc_reg != 31'h0) begin
              // Full reset time is M x constant
              divNum_reg <= INC_NUM;
              divDen_reg <= {14'h0, multReset, 16'h0};
              divStart_reg <= 1'b1;
              state_reg <= S_DEC;
            end
          end
        end
        S_RATIO: begin
          if (divDone) begin
            ratio_reg <= ratioNow;
            if (ratioNow <= `TOC_ONE_PU) begin
              // Between dropout and pickup the accumulator holds
              state_reg <= S_IDLE;
            end else if (isFormula(curve_reg)) begin
              divNum_reg <= `TOC_RECIP_NUM;
              divDen_reg <= {16'h0, ratioNow - cC};
              divStart_reg <= 1'b1;
              state_reg <= S_RECIP;
            end else begin
              state_reg <= S_BASE;
            end
          end
        end
        S_RECIP: begin
          if (divDone) begin
            y_reg <= (|divQuot[63:24]) ? 24'hffffff : divQuot[23:0];
            state_reg <= S_BASE;
          end
        end
        S_BASE: begin
          divNum_reg <= INC_NUM;
          divDen_reg <= {10'h0, incDen};
          divStart_reg <= 1'b1;
          state_reg <= S_INC;
        end
        S_INC: begin
          if (divDone) begin
            acc_reg <= (accSum > {1'b0, `TOC_FULL}) ? `TOC_FULL : accSum[30:0];
            state_reg <= S_IDLE;
          end
        end
        S_DEC: begin
          if (divDone) begin
            acc_reg <= (acc_reg > stepNow) ? acc_reg - stepNow : 31'h0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt

  wire evTrip = accFull & ~tripOut;
  wire evPick = sampleTick & pickNext & ~pickedUp;
  wire evDrop = sampleTick & ~pickNext & pickedUp;
  wire [`TOC_EV_BITS-1:0] events = {evDrop, evPick, evTrip};
  wire [`TOC_EV_BITS-1:0] clearBits =
    (regWr && regAddr == `TOC_ADDR_STATUS) ? regWdata[`TOC_EV_BITS-1:0] : {`TOC_EV_BITS{1'b0}};

  assign irq = |(status_reg & mask_reg);

  always @(posedge clk) begin
    if (reset) begin
      curve_reg <= `TOC_CURVE_RST;
      linear_reg <= 1'b0;
      pickup_reg <= `TOC_PICKUP_RST;
      mult_reg <= `TOC_MULT_RST;
      status_reg <= {`TOC_EV_BITS{1'b0}};
      mask_reg <= {`TOC_EV_BITS{1'b0}};
      tabSel_reg <= 1'b0;
      tabIdx_reg <= 7'h00;
      regRdata <= 32'h0;
    end else begin
      // A new event beats a simultaneous clear
      status_reg <= (status_reg & ~clearBits) | events;
      if (regWr) begin
        case (regAddr)
          `TOC_ADDR_CTRL: begin
            if (regWdata[`TOC_CTRL_CURVE_MSB:0] <= `TOC_CURVE_USER_B) begin
              curve_reg <= regWdata[`TOC_CTRL_CURVE_MSB:0];
            end
            linear_reg <= regWdata[`TOC_CTRL_LINEAR_BIT];
          end
          `TOC_ADDR_PICKUP: pickup_reg <= regWdata[15:0];
          `TOC_ADDR_MULT: begin
            mult_reg <= (regWdata[31:0] > {18'h0, `TOC_MULT_MAX}) ?
                        `TOC_MULT_MAX : regWdata[13:0];
          end
          `TOC_ADDR_MASK: mask_reg <= regWdata[`TOC_EV_BITS-1:0];
          `TOC_ADDR_TABADDR: begin
            tabSel_reg <= regWdata[7];
            tabIdx_reg <= regWdata[6:0];
          end
          // Auto-increment lets software stream a whole curve
          `TOC_ADDR_TABDATA: tabIdx_reg <= tabIdx_reg + 7'h01;
          default: begin
          end
        endcase
      end
      if (regRd) begin
        case (regAddr)
          `TOC_ADDR_CTRL: regRdata <= {27'h0, linear_reg, curve_reg};
          `TOC_ADDR_PICKUP: regRdata <= {16'h0, pickup_reg};
          `TOC_ADDR_MULT: regRdata <= {18'h0, mult_reg};
          `TOC_ADDR_STATUS: regRdata <= {29'h0, status_reg};
          `TOC_ADDR_MASK: regRdata <= {29'h0, mask_reg};
          `TOC_ADDR_STATE: regRdata <= {26'h0, state_reg, divBusy, pickedUp, tripOut};
          `TOC_ADDR_ACCUM: regRdata <= {1'b0, acc_reg};
          `TOC_ADDR_TABADDR: regRdata <= {24'h0, tabSel_reg, tabIdx_reg};
          `TOC_ADDR_TABDATA: regRdata <= {8'h0, tabReadback};
          default: regRdata <= 32'h0;
        endcase
      end else begin
        regRdata <= 32'h0;
      end
    end
  end

endmodule

`default_nettype wire

// file: test/toc_element_props.sv
// Port checker for the overcurrent element
`default_nettype none
`include "toc_regs.vh"

module toc_element_props #(
  parameter SAMPLE_CYCLES = 10000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] currentIn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic tripOut,
  input wire logic pickedUp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////
  // Shadows of the settings; sample phase
  logic [31:0] cnt;
  logic [15:0] pickupSh;
  logic [13:0] multSh;
  logic linSh;
  wire tick = (cnt == SAMPLE_CYCLES - 1);
  wire above = currentIn > pickupSh;
  wire below = ({16'h0, currentIn} * 32'h64) < ({16'h0, pickupSh} * 32'h62);

  always @(posedge clk) begin
    if (reset) begin
      cnt <= 32'h0;
      pickupSh <= `TOC_PICKUP_RST;
      multSh <= `TOC_MULT_RST;
      linSh <= 1'b0;
    end else begin
      cnt <= tick ? 32'h0 : cnt + 32'h1;
      if (regWr && regAddr == `TOC_ADDR_PICKUP) begin
        pickupSh <= regWdata[15:0];
      end
      // Clamp mirrors the saturation of multipliers above 100.00 to 100.00
      if (regWr && regAddr == `TOC_ADDR_MULT) begin
        multSh <= (regWdata > {18'h0, `TOC_MULT_MAX}) ? `TOC_MULT_MAX : regWdata[13:0];
      end
      if (regWr && regAddr == `TOC_ADDR_CTRL) begin
        linSh <= regWdata[`TOC_CTRL_LINEAR_BIT];
      end
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_pick_timing: assert property (!$stable(pickedUp) |-> cnt == 32'h0)
    else $error("pickup state moved between samples");
  a_pick_rise: assert property (tick && above |=> pickedUp)
    else $error("no pickup above threshold");
  a_drop_fall: assert property (tick && below |=> !pickedUp)
    else $error("no dropout below threshold");
  a_hyst_hold: assert property (tick && !above && !below |=> $stable(pickedUp))
    else $error("pickup state moved inside hysteresis band");
  a_zero_mult: assert property (tick && above && multSh == 14'h0 |-> ##2 tripOut)
    else $error("zero multiplier did not trip at once");
  a_instant_clear: assert property (tick && below && !linSh |-> ##2 !tripOut)
    else $error("trip held after instant reset");
  a_trip_cause: assert property ($rose(tripOut) |-> pickedUp)
    else $error("trip without pickup");
  a_rd_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");
  a_mult_read: assert property ($past(regRd && regAddr == `TOC_ADDR_MULT) |->
    regRdata == {18'h0, multSh})
    else $error("multiplier read back wrong");

  c_trip: cover property ($rose(tripOut));
  c_drop: cover property (tick && below && pickedUp);
  c_zero: cover property (tick && above && multSh == 14'h0);
endmodule

bind toc_element toc_element_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_props (
  .clk(clk), .reset(reset), .currentIn(currentIn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .tripOut(tripOut), .pickedUp(pickedUp), .irq(irq));
`default_nettype wire

// file: test/toc_front_end.sv
// Model of the current front end and the trip output logic
`default_nettype none

module toc_front_end (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] level,
  input wire logic tripOut,
  output logic [15:0] currentIn,
  output int tripCount
);
  timeunit 1ns;
  timeprecision 1ns;

  // Converter result moves on the clock, never mid-cycle
  always @(posedge clk) begin
    currentIn <= reset ? 16'h0 : level;
  end
  // Breaker coil operations
  always @(posedge tripOut) begin
    tripCount <= tripCount + 1;
  end
endmodule
`default_nettype wire

// file: test/toc_element_tb.sv
// Self-checking testbench for the overcurrent element
`default_nettype none
`include "toc_regs.vh"

module toc_element_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short sample period keeps the run small; increment scale unchanged
  localparam int SC = 400;
  localparam logic [63:0] INC = ((64'h1 << 46) * `TOC_SAMPLE_US) / 64'h2710;
  localparam logic [31:0] FULL = {1'b0, `TOC_FULL};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] level = 16'h0;
  logic [31:0] a;
  logic [31:0] d;
  wire [15:0] currentIn;
  wire [31:0] regRdata;
  wire tripOut;
  wire pickedUp;
  wire irq;
  int tripCount;
  int num_errors = 0;
  int compares = 0;
  int phase = 0;

  always #50 clk = ~clk;
  always @(posedge clk) phase <= reset ? 0 : (phase == SC - 1 ? 0 : phase + 1);

  toc_front_end i_fe (.clk(clk), .reset(reset), .level(level), .tripOut(tripOut),
    .currentIn(currentIn), .tripCount(tripCount));
  toc_element #(.SAMPLE_CYCLES(SC)) i_dut (.clk(clk), .reset(reset),
    .currentIn(currentIn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .tripOut(tripOut), .pickedUp(pickedUp),
    .irq(irq));

  ////////////////////////////////////////
  function automatic logic [31:0] sat(input logic [63:0] v);
    return (v > {32'h0, FULL}) ? FULL : v[31:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic expect_reg(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad, d);
    check(d, exp);
  endtask
  // Lands well after the engine has finished with the sample
  task automatic waitTick(input int n);
    repeat (n) begin
      @(posedge clk);
      while (phase != SC - 1) @(posedge clk);
    end
    repeat (250) @(posedge clk);
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    expect_reg(`TOC_ADDR_CTRL, 32'h0);
    expect_reg(`TOC_ADDR_PICKUP, 32'h100);
    expect_reg(`TOC_ADDR_MULT, 32'h64);
    expect_reg(`TOC_ADDR_STATUS, 32'h0);
    expect_reg(8'h40, 32'h0);
    wr(`TOC_ADDR_CTRL, 32'h1f);
    expect_reg(`TOC_ADDR_CTRL, 32'h10);
    wr(`TOC_ADDR_MULT, 32'h2ee0);
    expect_reg(`TOC_ADDR_MULT, 32'h2710);
    wr(`TOC_ADDR_MULT, 32'h10001);
    expect_reg(`TOC_ADDR_MULT, 32'h2710);
    wr(`TOC_ADDR_MULT, 32'h1);
    expect_reg(`TOC_ADDR_MULT, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_definite;
    int k;
    logic [63:0] incDt;
    incDt = INC / (64'ha * 64'h199a);
    level <= 16'h0101;
    wr(`TOC_ADDR_CTRL, 32'hc);
    wr(`TOC_ADDR_MULT, 32'ha);
    wr(`TOC_ADDR_MASK, 32'h1);
    for (k = 1; k <= 11; k++) begin
      waitTick(1);
      expect_reg(`TOC_ADDR_ACCUM, sat(k * incDt));
      check({31'h0, tripOut}, {31'h0, k == 11});
    end
    check({31'h0, irq}, 32'h1);
    check({31'h0, pickedUp}, 32'h1);
    wr(`TOC_ADDR_STATUS, 32'h1);
    expect_reg(`TOC_ADDR_STATUS, 32'h2);
    check({31'h0, irq}, 32'h0);
    $display("t_definite done");
  endtask
  task automatic t_dropout;
    level <= 16'h00fb;
    waitTick(1);
    expect_reg(`TOC_ADDR_ACCUM, FULL);
    check({31'h0, pickedUp}, 32'h1);
    level <= 16'h00fa;
    waitTick(1);
    expect_reg(`TOC_ADDR_ACCUM, 32'h0);
    expect_reg(`TOC_ADDR_STATUS, 32'h6);
    check({31'h0, pickedUp}, 32'h0);
    check({31'h0, tripOut}, 32'h0);
    check(tripCount, 32'h1);
    $display("t_dropout done");
  endtask
  task automatic t_linear;
    int i;
    logic [63:0] dec;
    for (i = 0; i < 2; i++) begin
      dec = INC / ((64'ha * (i == 1 ? 64'h8 : 64'h5)) << 16);
      level <= 16'h0400;
      wr(`TOC_ADDR_CTRL, i == 1 ? 32'h18 : 32'h1c);
      waitTick(1);
      rd(`TOC_ADDR_ACCUM, a);
      check({31'h0, a > dec[31:0]}, 32'h1);
      level <= 16'h0;
      waitTick(1);
      expect_reg(`TOC_ADDR_ACCUM, a - dec[31:0]);
    end
    wr(`TOC_ADDR_CTRL, 32'hc);
    waitTick(1);
    expect_reg(`TOC_ADDR_ACCUM, 32'h0);
    $display("t_linear done");
  endtask
  task automatic t_user;
    wr(`TOC_ADDR_TABADDR, 32'h7);
    wr(`TOC_ADDR_TABDATA, 32'h1000);
    expect_reg(`TOC_ADDR_TABADDR, 32'h8);
    wr(`TOC_ADDR_TABADDR, 32'h7);
    expect_reg(`TOC_ADDR_TABDATA, 32'h1000);
    level <= 16'h0200;
    wr(`TOC_ADDR_CTRL, 32'hd);
    wr(`TOC_ADDR_MULT, 32'h64);
    waitTick(1);
    expect_reg(`TOC_ADDR_ACCUM, sat(INC / 64'h64000));
    wr(`TOC_ADDR_MULT, 32'hc8);
    waitTick(1);
    expect_reg(`TOC_ADDR_ACCUM, sat(INC / 64'h64000 + INC / 64'hc8000));
    level <= 16'h0;
    waitTick(1);
    $display("t_user done");
  endtask
  task automatic t_curves;
    int c;
    logic [31:0] prev;
    prev = 32'h0;
    level <= 16'h0400;
    for (c = 0; c < 15; c++) begin
      wr(`TOC_ADDR_CTRL, c);
      waitTick(1);
      rd(`TOC_ADDR_ACCUM, a);
      check({31'h0, a > prev && a < FULL}, 32'h1);
      prev = a;
    end
    wr(`TOC_ADDR_MULT, 32'h0);
    waitTick(1);
    check({31'h0, tripOut}, 32'h1);
    level <= 16'h0;
    waitTick(1);
    check({31'h0, tripOut}, 32'h0);
    $display("t_curves done");
  endtask

  ////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_definite;
    t_dropout;
    t_linear;
    t_user;
    t_curves;
    conclude;
  end
  // About 40 samples of work; 100 samples is a hang
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire
